/* File: core/acc_defines.svh */
// Purpose: Register map, reset values and counts for the comparator control
// Assumes: 8-bit register port, byte offsets used as register addresses
// Notes: Definitions only
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// Register offsets
`define ACC_OFS_CTRL 8'h00
`define ACC_OFS_FLAG 8'h01
`define ACC_OFS_IEN 8'h02
`define ACC_OFS_FILT 8'h03
`define ACC_OFS_WIN 8'h04
`define ACC_OFS_REF 8'h05
`define ACC_OFS_OUT 8'h06
`define ACC_OFS_EVT 8'h07

// Field positions
`define ACC_CTRL_HS 4
`define ACC_CTRL_STOP 5
`define ACC_FILT_DIV 4

// Reset values
`define ACC_CTRL_RST 8'h20
`define ACC_ZERO_RST 8'h00

// Channel masks for the two variants
`define ACC_MASK_TWO 4'hF
`define ACC_MASK_ONE 4'hC

// Filter and sampling counts
`define ACC_FILT_LEN 3
`define ACC_DIV_W 6
`define ACC_DIV_M1 6'h03
`define ACC_DIV_M2 6'h0F
`define ACC_DIV_M3 6'h3F

`endif

/* File: core/acc_pkg.sv */
// Purpose: Shared types of the comparator control
// Assumes: Constants come from acc_defines.svh
// Notes: Types only
`default_nettype none

package acc_pkg;
    typedef logic [7:0] acc_addr_t;
    typedef logic [7:0] acc_data_t;
    typedef logic [3:0] acc_chv_t;
    typedef enum logic [1:0] {
        ACC_DIV_1 = 2'h0,
        ACC_DIV_4 = 2'h1,
        ACC_DIV_16 = 2'h2,
        ACC_DIV_64 = 2'h3
    } acc_div_t;
endpackage : acc_pkg

`default_nettype wire

/* File: core/acc_chan_if.sv */
// Purpose: Per-channel link between control, filter and change detector
// Assumes: One instance per comparator channel
// Notes: raw is already synchronised
`default_nettype none

interface acc_chan_if;
    logic raw;
    logic samp;
    logic fen;
    logic clr;
    logic res;
    logic chg;
    modport ctl (output raw, samp, fen, clr, input res, chg);
    modport flt (input raw, samp, fen, clr, output res);
    modport edg (input res, clr, output chg);
endinterface : acc_chan_if

`default_nettype wire

/* File: core/acc_filter.sv */
// Purpose: Digital noise filter for one comparator outcome
// Assumes: raw is synchronised to clk_i
// Notes: With the filter on, result moves only on a clear or when all samples agree
`include "acc_defines.svh"
`default_nettype none

module acc_filter
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Channel
    acc_chan_if.flt ch
);
    logic [`ACC_FILT_LEN-1:0] hist_reg;
    logic [`ACC_FILT_LEN-1:0] hist_next;
    logic res_reg;
    logic res_next;
    wire logic all_one = &hist_reg;
    wire logic all_zero = ~|hist_reg;

    assign hist_next = ch.clr ? '0 :
        ch.samp ? {hist_reg[`ACC_FILT_LEN-2:0], ch.raw} : hist_reg;
    // Bypass follows the input, filter needs a full agreeing history
    assign res_next = ch.clr ? 1'b0 : !ch.fen ? ch.raw :
        all_one ? 1'b1 : all_zero ? 1'b0 : res_reg; // [R6]
    assign ch.res = res_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hist_reg <= '0;
            res_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            hist_reg <= hist_next;
            res_reg <= res_next;
        end
    end

    filt_hold_a: assert property ( // [R6]
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && ch.fen && !ch.clr && !all_one && !all_zero) |=> res_reg == $past(res_reg))
        else $error("Filtered outcome moved without agreeing samples");
endmodule : acc_filter

`default_nettype wire

/* File: core/acc_edge.sv */
// Purpose: Change detector for one filtered outcome
// Assumes: res comes from a flip-flop on clk_i
// Notes: One pulse cycle per transition, either direction; none while cleared
`default_nettype none

module acc_edge
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Channel
    acc_chan_if.edg ch
);
    logic prev_reg;
    logic chg_reg;
    wire logic diff = ch.res ^ prev_reg;

    assign ch.chg = chg_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            prev_reg <= 1'b0;
            chg_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            prev_reg <= ch.res;
            chg_reg <= diff & !ch.clr; // [R11]
        end
    end

    chg_pulse_a: assert property ( // [R11]
        @(posedge clk_i) disable iff (!nrst_i)
        (ce_i && !ch.clr && diff) |=> chg_reg ##1 (!chg_reg || !$past(ce_i) || $past(diff)))
        else $error("Change pulse missing or stretched");
endmodule : acc_edge

`default_nettype wire

/* File: core/acc_ctrl.sv */
// Purpose: Control logic of a dual-channel-unit voltage comparator
// Assumes: Analog macro gives raw compare levels; registers on a strobe port
// Notes: All analog levels pass a two-stage synchroniser first
//
// How it works
// [R1] Channels come in units of two
// [R2] Readable per-channel result bit
// [R3] Outcome drivable onto per-channel output pin
// [R4] Per-channel interrupt on outcome change
// [R5] Events on channel 0, or 0/1 change
// [R6] Filter bypass or apply, selectable sampling
// [R7] Window mode: between low and high reference
// [R8] Reference from pin or internal source
// [R9] High or low response speed select
// [R10] Module stop halts comparators
// [R11] Filtered changes give one-cycle pulses
//
// The address-and-strobe port and the placing of the registers were decided locally.
`include "acc_defines.svh"
`default_nettype none

module acc_ctrl
    import acc_pkg::*;
#(
    parameter int UNITS = 2
)
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Register port
    input wire acc_addr_t addr_i,
    input wire acc_data_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output acc_data_t rdata_o,
    // Analog compare levels
    input wire acc_chv_t above_ref_pin_i,
    input wire acc_chv_t above_ref_int_i,
    input wire acc_chv_t above_win_low_i,
    input wire acc_chv_t below_win_high_i,
    // Analog control
    output acc_chv_t ana_en_o,
    output acc_chv_t ref_int_o,
    output logic high_speed_o,
    // Comparator output pins
    output acc_chv_t cmp_out_o,
    output acc_chv_t cmp_out_en_o,
    // Requests
    output acc_chv_t irq_o,
    output logic [1:0] evt_o
);
    localparam acc_chv_t PRESENT = (UNITS == 2) ? `ACC_MASK_TWO : `ACC_MASK_ONE; // [R1]
    localparam logic EVT_ON = (UNITS == 2);

    function automatic logic hit(input acc_addr_t a, input acc_addr_t ofs);
        hit = (a == ofs);
    endfunction : hit

    // Control registers
    acc_chv_t ch_en_reg;
    logic hs_reg;
    logic stop_reg;
    acc_chv_t ien_reg;
    acc_chv_t fen_reg;
    acc_div_t div_reg;
    logic [1:0] win_reg;
    acc_chv_t ref_reg;
    acc_chv_t oe_reg;
    logic [1:0] evt_en_reg;

    // Synchroniser stages, second stage alone feeds logic
    // Reset to the idle level so no false change follows reset
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    wire logic [15:0] raw_all = {below_win_high_i, above_win_low_i, above_ref_int_i, above_ref_pin_i};
    wire acc_chv_t pin_s = sync2_reg[3:0];
    wire acc_chv_t int_s = sync2_reg[7:4];
    wire acc_chv_t lo_s = sync2_reg[11:8];
    wire acc_chv_t hi_s = sync2_reg[15:12];

    // Sampling divider
    logic [`ACC_DIV_W-1:0] div_cnt_reg;
    logic [`ACC_DIV_W-1:0] div_mask;
    wire logic samp = ((div_cnt_reg & div_mask) == '0); // [R6]

    // Output registers
    acc_data_t rdata_reg;
    acc_data_t rdata_next;
    acc_chv_t ana_en_reg;
    acc_chv_t cmp_out_reg;
    acc_chv_t irq_reg;
    logic [1:0] evt_reg;

    // Per-channel results
    acc_chv_t sel_v;
    acc_chv_t res_v;
    acc_chv_t chg_v;
    acc_chv_t clr_v;

    // Write decode
    wire logic wr_ctrl = wr_i && hit(addr_i, `ACC_OFS_CTRL);
    wire logic wr_ien = wr_i && hit(addr_i, `ACC_OFS_IEN);
    wire logic wr_filt = wr_i && hit(addr_i, `ACC_OFS_FILT);
    wire logic wr_win = wr_i && hit(addr_i, `ACC_OFS_WIN);
    wire logic wr_ref = wr_i && hit(addr_i, `ACC_OFS_REF);
    wire logic wr_out = wr_i && hit(addr_i, `ACC_OFS_OUT);
    wire logic wr_evt = wr_i && hit(addr_i, `ACC_OFS_EVT);

    // One tick source for all channels; a per-channel phase would cost a counter each
    always_comb
    begin
        case (div_reg)
            ACC_DIV_1: div_mask = '0;
            ACC_DIV_4: div_mask = `ACC_DIV_M1;
            ACC_DIV_16: div_mask = `ACC_DIV_M2;
            default: div_mask = `ACC_DIV_M3;
        endcase
    end

    // Read decode; unmapped offsets read zero
    always_comb
    begin
        if (hit(addr_i, `ACC_OFS_CTRL))
            rdata_next = {2'h0, stop_reg, hs_reg, ch_en_reg};
        else if (hit(addr_i, `ACC_OFS_FLAG))
            rdata_next = {4'h0, res_v}; // [R2]
        else if (hit(addr_i, `ACC_OFS_IEN))
            rdata_next = {4'h0, ien_reg};
        else if (hit(addr_i, `ACC_OFS_FILT))
            rdata_next = {2'h0, div_reg, fen_reg};
        else if (hit(addr_i, `ACC_OFS_WIN))
            rdata_next = {6'h00, win_reg};
        else if (hit(addr_i, `ACC_OFS_REF))
            rdata_next = {4'h0, ref_reg};
        else if (hit(addr_i, `ACC_OFS_OUT))
            rdata_next = {4'h0, oe_reg};
        else if (hit(addr_i, `ACC_OFS_EVT))
            rdata_next = {6'h00, evt_en_reg};
        else
            rdata_next = `ACC_ZERO_RST;
    end

    // Register file; absent channels keep their bits at zero
    // Reset leaves the module stopped, so the analog side draws no power
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            {stop_reg, hs_reg, ch_en_reg} <= 6'(`ACC_CTRL_RST);
            ien_reg <= '0;
            fen_reg <= '0;
            div_reg <= ACC_DIV_1;
            win_reg <= '0;
            ref_reg <= '0;
            oe_reg <= '0;
            evt_en_reg <= '0;
        end
        else if (ce_i)
        begin
            if (wr_ctrl)
            begin
                ch_en_reg <= wdata_i[3:0] & PRESENT; // [R1]
                hs_reg <= wdata_i[`ACC_CTRL_HS]; // [R9]
                stop_reg <= wdata_i[`ACC_CTRL_STOP]; // [R10]
            end
            if (wr_ien)
                ien_reg <= wdata_i[3:0] & PRESENT;
            if (wr_filt)
            begin
                fen_reg <= wdata_i[3:0] & PRESENT; // [R6]
                div_reg <= acc_div_t'(wdata_i[`ACC_FILT_DIV+:2]); // [R6]
            end
            if (wr_win)
                win_reg <= wdata_i[1:0] & {PRESENT[2], PRESENT[0]}; // [R7]
            if (wr_ref)
                ref_reg <= wdata_i[3:0] & PRESENT; // [R8]
            if (wr_out)
                oe_reg <= wdata_i[3:0] & PRESENT;
            if (wr_evt)
                evt_en_reg <= wdata_i[1:0] & {2{EVT_ON}};
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            div_cnt_reg <= '0;
        end
        else if (ce_i)
        begin
            sync1_reg <= raw_all;
            sync2_reg <= sync1_reg;
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // Per-channel path: select, filter, detect change
    acc_chan_if chn[4] ();

    for (genvar i = 0; i < 4; i++)
    begin : g_ch
        // Window compares against both levels, strict on each side
        assign sel_v[i] = win_reg[i/2] ? (lo_s[i] & hi_s[i]) : // [R7]
            ref_reg[i] ? int_s[i] : pin_s[i]; // [R8]
        // Stopped or disabled channels hold a cleared outcome
        assign clr_v[i] = stop_reg | !ch_en_reg[i]; // [R10]
        assign chn[i].raw = sel_v[i];
        assign chn[i].samp = samp;
        assign chn[i].fen = fen_reg[i];
        assign chn[i].clr = clr_v[i];
        assign res_v[i] = chn[i].res;
        assign chg_v[i] = chn[i].chg;

        // Both stages share the channel bundle, so a clear reaches each
        acc_filter u_filter (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .ce_i(ce_i),
            .ch(chn[i])
        );

        acc_edge u_edge (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .ce_i(ce_i),
            .ch(chn[i])
        );
    end

    // Outputs, each from its own flip-flop
    // Requests lag the result by two edges, so the flag is seen first
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_reg <= '0;
            ana_en_reg <= '0;
            cmp_out_reg <= '0;
            irq_reg <= '0;
            evt_reg <= '0;
        end
        else if (ce_i)
        begin
            // Read data stands for one cycle only
            rdata_reg <= rd_i ? rdata_next : `ACC_ZERO_RST;
            ana_en_reg <= ch_en_reg & {4{!stop_reg}}; // [R10]
            cmp_out_reg <= res_v & oe_reg; // [R3]
            irq_reg <= chg_v & ien_reg; // [R4]
            evt_reg[0] <= chg_v[0] & evt_en_reg[0]; // [R5]
            evt_reg[1] <= (chg_v[0] | chg_v[1]) & evt_en_reg[1]; // [R5]
        end
    end

    assign rdata_o = rdata_reg;
    assign ana_en_o = ana_en_reg;
    assign ref_int_o = ref_reg;
    assign high_speed_o = hs_reg;
    assign cmp_out_o = cmp_out_reg;
    assign cmp_out_en_o = oe_reg;
    assign irq_o = irq_reg;
    assign evt_o = evt_reg;

    // Checks share the one clock; reset masks them all
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    flag_read_a: assert property ( // [R2]
        (ce_i && rd_i && hit(addr_i, `ACC_OFS_FLAG)) |=> rdata_o == {4'h0, $past(res_v)})
        else $error("Flag read does not show the outcome");

    pin_drive_a: assert property ( // [R3]
        (ce_i && oe_reg[3] && !stop_reg) ##1 (ce_i && oe_reg[3]) |=> cmp_out_o[3] == $past(res_v[3]))
        else $error("Output pin does not carry the outcome");

    irq_change_a: assert property ( // [R4]
        (ce_i && $changed(res_v[3]) && !clr_v[3] && ien_reg[3]) ##1 (ce_i && ien_reg[3]) |=> irq_o[3])
        else $error("Outcome change raised no interrupt");

    irq_cause_a: assert property ( // [R11]
        irq_o[2] |-> $past(chg_v[2]) && $past(ien_reg[2]))
        else $error("Interrupt without a change");

    evt_ch0_a: assert property ( // [R5]
        (ce_i && $changed(res_v[0]) && !clr_v[0] && evt_en_reg == 2'h3) ##1 ce_i |=> evt_o == 2'h3)
        else $error("Channel 0 change gave no event");

    bypass_path_a: assert property ( // [R6]
        (ce_i && !fen_reg[2] && !clr_v[2] && !win_reg[1] && !ref_reg[2]) |=> res_v[2] == $past(pin_s[2]))
        else $error("Unfiltered outcome does not follow the input");

    window_mode_a: assert property ( // [R7]
        (ce_i && win_reg[1] && !fen_reg[3] && !clr_v[3]) |=> res_v[3] == $past(lo_s[3] && hi_s[3]))
        else $error("Window outcome wrong");

    ref_internal_a: assert property ( // [R8]
        (ce_i && !win_reg[1] && ref_reg[2] && !fen_reg[2] && !clr_v[2]) |=> res_v[2] == $past(int_s[2]))
        else $error("Internal reference not used");

    speed_sel_a: assert property ( // [R9]
        (ce_i && wr_ctrl) |=> high_speed_o == $past(wdata_i[`ACC_CTRL_HS]))
        else $error("Speed select not taken");

    stop_quiet_a: assert property ( // [R10]
        (ce_i && stop_reg) |=> res_v == '0 && ana_en_o == '0)
        else $error("Module stop leaves channels running");

    absent_chan_a: assert property ( // [R1]
        (res_v & ~PRESENT) == '0 && (irq_o & ~PRESENT) == '0)
        else $error("Absent channel is active");

    evt_ch1_a: assert property ( // [R5]
        (ce_i && $changed(res_v[1]) && !clr_v[1] && evt_en_reg[1]) ##1 (ce_i && evt_en_reg[1]) |=> evt_o[1])
        else $error("Channel 1 change gave no event");

    clear_quiet_a: assert property ( // [R11]
        (ce_i && clr_v[3]) ##1 ce_i |=> !irq_o[3])
        else $error("Cleared channel raised an interrupt");

    ana_power_a: assert property ( // [R10]
        (ce_i && !stop_reg) |=> ana_en_o == $past(ch_en_reg))
        else $error("Comparator power does not follow the enables");

    ce_freeze_a: assert property ( // [R2]
        !ce_i |=> $stable(res_v) && $stable(rdata_o))
        else $error("State moved while the clock enable was low");

    rd_idle_a: assert property ( // [R2]
        (ce_i && !rd_i) |=> rdata_o == '0)
        else $error("Read data stood outside its cycle");

    // Main scenarios the bench must reach
    ch0_toggle_c: cover property (ce_i && chg_v[0] && evt_en_reg[0]);
    irq_seen_c: cover property (irq_o[3] && fen_reg[3]);
    window_hit_c: cover property (win_reg[1] && res_v[3]);
    stop_exit_c: cover property ($fell(stop_reg));
    freeze_seen_c: cover property (!ce_i && ana_en_o != '0);
endmodule : acc_ctrl

`default_nettype wire

/* File: test/acc_ana_model.sv */
// Purpose: Analog side of the four comparator channels
// Assumes: Voltages are 8-bit codes, all comparisons strict
// Notes: An unselected reference path shows the wrong level on purpose
`default_nettype none

module acc_ana_model
    import acc_pkg::*;
(
    // Voltages
    input wire logic [3:0][7:0] vin_i,
    input wire logic [3:0][7:0] vref_i,
    input wire logic [7:0] vint_i,
    input wire logic [7:0] vlow_i,
    input wire logic [7:0] vhigh_i,
    // Control from the block
    input wire acc_chv_t ana_en_i,
    input wire acc_chv_t ref_int_i,
    // Compare levels
    output acc_chv_t above_ref_pin_o,
    output acc_chv_t above_ref_int_o,
    output acc_chv_t above_win_low_o,
    output acc_chv_t below_win_high_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Powered-down comparators give no result
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            above_ref_pin_o[i] = ana_en_i[i] & (ref_int_i[i] ^ (vin_i[i] > vref_i[i]));
            above_ref_int_o[i] = ana_en_i[i] & (~ref_int_i[i] ^ (vin_i[i] > vint_i));
            above_win_low_o[i] = ana_en_i[i] & (vin_i[i] > vlow_i);
            below_win_high_o[i] = ana_en_i[i] & (vin_i[i] < vhigh_i);
        end
    end
endmodule : acc_ana_model

`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench of the comparator control
// Assumes: Two-unit variant, analog model on the far side
// Notes: Requests and read data are checked against queued notes
`include "acc_defines.svh"
`default_nettype none

module tb_top
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    acc_addr_t addr_i = 8'h00;
    acc_data_t wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    acc_data_t rdata_o;
    acc_chv_t ana_en_o, ref_int_o, cmp_out_o, cmp_out_en_o, irq_o;
    logic high_speed_o;
    logic [1:0] evt_o;
    wire acc_chv_t above_pin, above_int, above_low, below_high;
    logic [3:0][7:0] vin = '0;
    logic [3:0][7:0] vref = {4{8'h80}};
    logic [7:0] vint = 8'h64;
    logic [7:0] vlow = 8'h40;
    logic [7:0] vhigh = 8'hC0;
    logic [7:0] rd_q[$];
    logic [7:0] ev_q[$];
    logic rd_d = 1'b0;
    int mismatches = 0;
    int comparisons = 0;

    acc_ctrl #(.UNITS(2)) i_acc_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .above_ref_pin_i(above_pin),
        .above_ref_int_i(above_int), .above_win_low_i(above_low), .below_win_high_i(below_high),
        .ana_en_o(ana_en_o), .ref_int_o(ref_int_o), .high_speed_o(high_speed_o), .cmp_out_o(cmp_out_o),
        .cmp_out_en_o(cmp_out_en_o), .irq_o(irq_o), .evt_o(evt_o));

    acc_ana_model i_acc_ana_model (.vin_i(vin), .vref_i(vref), .vint_i(vint), .vlow_i(vlow), .vhigh_i(vhigh),
        .ana_en_i(ana_en_o), .ref_int_i(ref_int_o), .above_ref_pin_o(above_pin), .above_ref_int_o(above_int),
        .above_win_low_o(above_low), .below_win_high_o(below_high));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic print_verdict;
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic wr(input acc_addr_t a, input acc_data_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input acc_addr_t a, input acc_data_t exp);
        rd_q.push_back(exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask : rd

    // Ideal outcome from the voltages; window wins over reference select
    function automatic acc_chv_t exp_flag(input logic [1:0] win, input acc_chv_t rsel);
        acc_chv_t f;
        for (int i = 0; i < 4; i++)
            f[i] = win[i / 2] ? (vin[i] > vlow && vin[i] < vhigh) : rsel[i] ? vin[i] > vint : vin[i] > vref[i];
        return f;
    endfunction : exp_flag

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_i)
    begin
        if (rd_d)
            check("rdata", rd_q.pop_front(), rdata_o);
        if ({evt_o, irq_o} !== 6'h00)
            check("requests", ev_q.pop_front(), {2'b00, evt_o, irq_o});
        rd_d <= rd_i;
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        int div;
        logic [1:0] win;
        acc_chv_t rsel;
        void'($urandom(32'h8efb_c21a));
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        cyc(1);
        check("ana_en", 8'h00, {4'h0, ana_en_o});
        for (int a = 0; a < 9; a++)
            rd(8'(a), a == 0 ? `ACC_CTRL_RST : `ACC_ZERO_RST);
        wr(`ACC_OFS_CTRL, 8'h0F);
        cyc(1);
        check("speed", 8'h00, {7'h00, high_speed_o});
        check("ana_en", 8'h0F, {4'h0, ana_en_o});
        wr(`ACC_OFS_CTRL, 8'h1F);
        wr(`ACC_OFS_OUT, 8'h0F);
        wr(`ACC_OFS_IEN, 8'h0F);
        wr(`ACC_OFS_EVT, 8'h03);
        wr(8'h08, 8'hFF);
        wr(`ACC_OFS_FLAG, 8'hFF);
        cyc(1);
        check("speed", 8'h01, {7'h00, high_speed_o});
        check("out_en", 8'h0F, {4'h0, cmp_out_en_o});
        rd(8'h08, 8'h00);
        rd(`ACC_OFS_FLAG, 8'h00);
        rd(`ACC_OFS_CTRL, 8'h1F);
        // Each channel up and down: one request pulse per edge
        for (int ch = 0; ch < 4; ch++)
        begin
            ev_q.push_back({2'b00, ch < 2, ch == 0, 4'(1 << ch)});
            vin[ch] <= 8'hC8;
            cyc(8);
            check("pins", 8'(1 << ch), {4'h0, cmp_out_o});
            ev_q.push_back({2'b00, ch < 2, ch == 0, 4'(1 << ch)});
            vin[ch] <= 8'h00;
            cyc(8);
        end
        // Clock enable low: nothing moves, then the change goes through
        @(posedge clk_i);
        ce_i <= 1'b0;
        vin[1] <= 8'hC8;
        cyc(20);
        check("frozen", 8'h00, {4'h0, cmp_out_o});
        ev_q.push_back(8'h22);
        @(posedge clk_i);
        ce_i <= 1'b1;
        cyc(8);
        check("pins", 8'h02, {4'h0, cmp_out_o});
        ev_q.push_back(8'h22);
        vin[1] <= 8'h00;
        cyc(8);
        // Filter: every divider; at dividers 4, 16 and 64 an early read must still show the old outcome
        wr(`ACC_OFS_IEN, 8'h04);
        for (int d = 0; d < 4; d++)
        begin
            div = 1 << (2 * d);
            wr(`ACC_OFS_FILT, {2'b00, 2'(d), 4'h4});
            if (d == 3)
            begin
                vin[2] <= 8'hC8;
                cyc(1);
                vin[2] <= 8'h00;
                cyc(300);
                rd(`ACC_OFS_FLAG, 8'h00);
            end
            for (int lvl = 1; lvl >= 0; lvl--)
            begin
                ev_q.push_back(8'h04);
                vin[2] <= lvl ? 8'hC8 : 8'h00;
                if (d > 0)
                begin
                    cyc(2 * div - 2);
                    rd(`ACC_OFS_FLAG, lvl ? 8'h00 : 8'h04);
                end
                cyc(4 * div + 10);
                rd(`ACC_OFS_FLAG, lvl ? 8'h04 : 8'h00);
            end
        end
        // Random voltages, window and reference; requests masked
        wr(`ACC_OFS_IEN, 8'h00);
        wr(`ACC_OFS_EVT, 8'h00);
        wr(`ACC_OFS_FILT, 8'h00);
        repeat (12)
        begin
            win = 2'($urandom());
            rsel = 4'($urandom());
            for (int i = 0; i < 4; i++)
            begin
                vin[i] <= 8'($urandom());
                vref[i] <= 8'($urandom());
            end
            wr(`ACC_OFS_WIN, {6'h00, win});
            wr(`ACC_OFS_REF, {4'h0, rsel});
            cyc(6);
            check("ref_int", {4'h0, rsel}, {4'h0, ref_int_o});
            rd(`ACC_OFS_FLAG, {4'h0, exp_flag(win, rsel)});
            check("pins", {4'h0, exp_flag(win, rsel)}, {4'h0, cmp_out_o});
        end
        vin <= {4{8'hC8}};
        cyc(6);
        wr(`ACC_OFS_CTRL, 8'h3F);
        cyc(3);
        check("ana_en", 8'h00, {4'h0, ana_en_o});
        check("pins", 8'h00, {4'h0, cmp_out_o});
        rd(`ACC_OFS_FLAG, 8'h00);
        cyc(3);
        check("pending", 8'h00, 8'(ev_q.size()));
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
